// file: hw/cfg_sw_pkg.sv
// Package for the switch configuration decoder: constants, types.
// Assumes a 50 MHz system clock.
package cfg_sw_pkg;
    localparam int unsigned CLK_HZ = 50000000;
    localparam int unsigned SEC_CYCLES = CLK_HZ;
    localparam logic [7:0] ADDR_LOW_BASE = 8'ha0;
    localparam logic [7:0] ADDR_HIGH_BASE = 8'hb0;
    localparam logic [7:0] LUM_GATE_MAX = 8'hc8;
    localparam logic [7:0] HOLD_S_0 = 8'h06;
    localparam logic [7:0] HOLD_S_1 = 8'h10;
    localparam logic [7:0] HOLD_S_2 = 8'h21;
    localparam logic [7:0] HOLD_S_3 = 8'h42;
    localparam logic [7:0] HOLD_S_4 = 8'h83;
    localparam logic [7:0] HOLD_S_UNDEF = 8'h83;
    localparam logic [9:0] SW_RESET = 10'h000;
    localparam logic [3:0] ROT_RESET = 4'h0;

    typedef enum logic [1:0] {
        SENS_MAX = 2'b00,
        SENS_HIGH = 2'b01,
        SENS_LOW = 2'b10,
        SENS_MIN = 2'b11
    } sens_t;

    typedef struct packed {
        logic proto_ascii;
        logic sw_config;
        logic init_mode;
        logic lum_gate;
        sens_t sens;
        logic [2:0] hold_code;
        logic [7:0] node_addr;
    } cfg_t;
endpackage : cfg_sw_pkg

// file: hw/dip_switch_config_decoder.sv
// Decodes switch bank and rotary switch into working configuration and
// runs the relay hold timer. Switches are asynchronous static levels.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Switch-derived address, mode, luminance, sensitivity and hold settings apply only with switch two OFF.
// - Switch one ON selects the vendor ASCII protocol, OFF selects Modbus RTU.
// - Switch two ON takes configuration from software, OFF from the switches.
// - Rotary 0..F maps to address 176..191 with switch three ON, else 160..175.
// - Switch four ON selects init mode, OFF normal mode.
// - Switch five ON accepts motion only with luminance 0..200, OFF always.
// - Switches six and seven give sensitivity maximum, high, low, minimum.
// - A software address may be any value 1 to 255.
module dip_switch_config_decoder #(
    parameter int unsigned SEC_CYCLES = cfg_sw_pkg::SEC_CYCLES
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [9:0] config_switch_i,
    input wire logic [3:0] rotary_i,
    input wire logic [7:0] sw_node_addr_i,
    input wire logic sw_init_mode_i,
    input wire logic sw_lum_gate_i,
    input wire logic [1:0] sw_sens_i,
    input wire logic [2:0] sw_hold_code_i,
    input wire logic [7:0] luminance_i,
    input wire logic motion_i,
    output logic proto_ascii_o,
    output logic sw_config_o,
    output logic [7:0] node_addr_o,
    output logic init_mode_o,
    output logic lum_gate_o,
    output logic [1:0] sens_o,
    output logic [2:0] hold_code_o,
    output logic relay_o
);
    typedef struct packed {
        logic [9:0] sw1;
        logic [9:0] sw2;
        logic [3:0] rot1;
        logic [3:0] rot2;
        logic mot1;
        logic mot2;
        cfg_sw_pkg::cfg_t cfg;
        logic relay;
        logic [31:0] tick;
        logic [7:0] secs;
    } state_t;

    state_t s_q, s_d;
    logic [7:0] hold_secs;
    logic qualified;

    always_comb begin
        case (s_q.cfg.hold_code)
            3'b000: hold_secs = cfg_sw_pkg::HOLD_S_0;
            3'b001: hold_secs = cfg_sw_pkg::HOLD_S_1;
            3'b010: hold_secs = cfg_sw_pkg::HOLD_S_2;
            3'b011: hold_secs = cfg_sw_pkg::HOLD_S_3;
            3'b100: hold_secs = cfg_sw_pkg::HOLD_S_4;
            default: hold_secs = cfg_sw_pkg::HOLD_S_UNDEF;
        endcase
    end

    // Luminance gate qualifies the synchronised motion by comparing luminance_i against the threshold
    assign qualified = s_q.mot2 && (!s_q.cfg.lum_gate ||
        (luminance_i <= cfg_sw_pkg::LUM_GATE_MAX));

    always_comb begin
        s_d = s_q;
        // Two-flop synchronisers for switch, rotary and motion levels
        s_d.sw1 = config_switch_i;
        s_d.sw2 = s_q.sw1;
        s_d.rot1 = rotary_i;
        s_d.rot2 = s_q.rot1;
        s_d.mot1 = motion_i;
        s_d.mot2 = s_q.mot1;
        s_d.cfg.proto_ascii = s_q.sw2[0];
        s_d.cfg.sw_config = s_q.sw2[1];
        // Hardware source decodes the bank; software source takes ports
        if (!s_q.sw2[1]) begin
            s_d.cfg.node_addr = (s_q.sw2[2] ? cfg_sw_pkg::ADDR_HIGH_BASE
                : cfg_sw_pkg::ADDR_LOW_BASE) | {4'h0, s_q.rot2};
            s_d.cfg.init_mode = s_q.sw2[3];
            s_d.cfg.lum_gate = s_q.sw2[4];
            s_d.cfg.sens = cfg_sw_pkg::sens_t'({s_q.sw2[5], s_q.sw2[6]});
            s_d.cfg.hold_code = {s_q.sw2[7], s_q.sw2[8], s_q.sw2[9]};
        end else begin
            if (sw_node_addr_i != 8'h00) begin
                s_d.cfg.node_addr = sw_node_addr_i;
            end
            s_d.cfg.init_mode = sw_init_mode_i;
            s_d.cfg.lum_gate = sw_lum_gate_i;
            s_d.cfg.sens = cfg_sw_pkg::sens_t'(sw_sens_i);
            s_d.cfg.hold_code = sw_hold_code_i;
        end
        // Countdown: one second every SEC_CYCLES cycles, retrigger reloads
        if (qualified) begin
            s_d.relay = 1'b1;
            s_d.secs = hold_secs;
            s_d.tick = 32'h0;
        end else if (s_q.relay) begin
            if (s_q.tick == 32'(SEC_CYCLES - 1)) begin
                s_d.tick = 32'h0;
                s_d.secs = s_q.secs - 8'h01;
                if (s_q.secs == 8'h01) begin
                    s_d.relay = 1'b0;
                end
            end else begin
                s_d.tick = s_q.tick + 32'h1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '0;
            s_q.cfg.node_addr <= cfg_sw_pkg::ADDR_LOW_BASE;
        end else begin
            s_q <= s_d;
        end
    end

    assign proto_ascii_o = s_q.cfg.proto_ascii;
    assign sw_config_o = s_q.cfg.sw_config;
    assign node_addr_o = s_q.cfg.node_addr;
    assign init_mode_o = s_q.cfg.init_mode;
    assign lum_gate_o = s_q.cfg.lum_gate;
    assign sens_o = s_q.cfg.sens;
    assign hold_code_o = s_q.cfg.hold_code;
    assign relay_o = s_q.relay;

    AST_PROTO: assert property (@(posedge clk_i) disable iff (!rstn_i)
        proto_ascii_o == $past(s_q.sw2[0]))
        else $error("protocol select wrong");
    AST_SRC: assert property (@(posedge clk_i) disable iff (!rstn_i)
        sw_config_o == $past(s_q.sw2[1]))
        else $error("config source wrong");
    AST_ADDR: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !$past(s_q.sw2[1]) |-> node_addr_o ==
        ({3'b101, $past(s_q.sw2[2]), $past(s_q.rot2)}))
        else $error("switch address wrong");
    AST_HWHOLD: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !$past(s_q.sw2[1]) |-> init_mode_o == $past(s_q.sw2[3])
        && hold_code_o == {$past(s_q.sw2[7]), $past(s_q.sw2[8]),
        $past(s_q.sw2[9])})
        else $error("hardware settings not applied");

    // Luminance gate follows switch five in hardware source
    AST_HWLUM: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !$past(s_q.sw2[1]) |-> lum_gate_o == $past(s_q.sw2[4]))
        else $error("luminance gate switch wrong");

    // Software source takes the mode, gate and hold ports
    AST_SWMODE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $past(s_q.sw2[1]) |-> init_mode_o == $past(sw_init_mode_i)
        && lum_gate_o == $past(sw_lum_gate_i)
        && hold_code_o == $past(sw_hold_code_i))
        else $error("software settings not applied");

    // A zero software address keeps the previous one
    AST_ZEROADDR: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $past(s_q.sw2[1]) && $past(sw_node_addr_i) == 8'h00
        |-> $stable(node_addr_o))
        else $error("zero software address taken");
    AST_SWADDR: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $past(s_q.sw2[1]) && $past(sw_node_addr_i) != 8'h00
        |-> node_addr_o == $past(sw_node_addr_i))
        else $error("software address wrong");
    AST_GATE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_q.mot2 && lum_gate_o && luminance_i > 8'hc8 && !relay_o
        |=> !relay_o)
        else $error("gated motion fired relay");
    AST_TRIG: assert property (@(posedge clk_i) disable iff (!rstn_i)
        qualified |=> relay_o && s_q.secs == $past(hold_secs))
        else $error("trigger did not load hold");

    // Relay must stay on while seconds remain
    AST_HOLDON: assert property (@(posedge clk_i) disable iff (!rstn_i)
        relay_o && !qualified && s_q.secs > 8'h01 |=> relay_o)
        else $error("relay dropped early");

    // Relay must drop at the end of the last second
    AST_EXPIRE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        relay_o && !qualified && s_q.secs == 8'h01
        && s_q.tick == 32'(SEC_CYCLES - 1) |=> !relay_o)
        else $error("relay did not expire");

    // Seconds only move at the end of a tick period
    AST_TICK: assert property (@(posedge clk_i) disable iff (!rstn_i)
        relay_o && !qualified && s_q.tick != 32'(SEC_CYCLES - 1)
        |=> s_q.secs == $past(s_q.secs))
        else $error("seconds moved mid tick");

    // No relay without a qualified trigger
    AST_NOGHOST: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !relay_o && !qualified |=> !relay_o)
        else $error("relay rose without trigger");
    AST_SENS: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !$past(s_q.sw2[1]) |-> sens_o ==
        {$past(s_q.sw2[5]), $past(s_q.sw2[6])})
        else $error("sensitivity wrong");
    AST_HOLDTAB: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_q.cfg.hold_code == 3'b010 |-> hold_secs == 8'd33)
        else $error("hold table wrong");
    AST_UNDEF: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_q.cfg.hold_code[2] |-> hold_secs == 8'd131)
        else $error("undefined hold code");

    COV_TRIG: cover property (@(posedge clk_i) disable iff (!rstn_i)
        qualified ##1 relay_o);
    COV_EXPIRE: cover property (@(posedge clk_i) disable iff (!rstn_i)
        relay_o ##1 !relay_o);
    COV_SWSRC: cover property (@(posedge clk_i) disable iff (!rstn_i)
        sw_config_o && node_addr_o == 8'h01);
    COV_UNDEF: cover property (@(posedge clk_i) disable iff (!rstn_i)
        qualified && s_q.cfg.hold_code == 3'b101);
endmodule // dip_switch_config_decoder

`default_nettype wire

// file: test/switch_bank_model.sv
// Model of the switch bank and rotary switch: static levels.
// Assumes the bench moves them just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module switch_bank_model (
    output var logic [9:0] config_switch_o,
    output var logic [3:0] rotary_o
);
    initial begin
        config_switch_o = 10'h000;
        rotary_o = 4'h0;
    end
    task automatic set_pos(input logic [9:0] s, input logic [3:0] r);
        config_switch_o <= s;
        rotary_o <= r;
    endtask
endmodule // switch_bank_model
`default_nettype wire

// file: test/tb_dip_switch_config_decoder.sv
// Self-checking bench for the switch configuration decoder.
// Assumes a hold second of 4 clock cycles in simulation.
`timescale 1ns/100ps
`default_nettype none
module tb_dip_switch_config_decoder;
    logic clk_i = 1'b0, rstn_i = 1'b0, sw_init = 1'b0, sw_lum = 1'b0;
    logic motion = 1'b0, relay, proto, swc, init, lum;
    logic [9:0] sw;
    logic [3:0] rot;
    logic [7:0] sw_addr = 8'h01, lumi = 8'h00, addr;
    logic [1:0] sw_sens = 2'h0, sens;
    logic [2:0] sw_hold = 3'h0, hold;
    int failures = 0, checks_done = 0;
    int secs[6] = '{6, 16, 33, 66, 131, 131};
    always #10 clk_i = ~clk_i;
    switch_bank_model bank (.config_switch_o(sw), .rotary_o(rot));
    dip_switch_config_decoder #(.SEC_CYCLES(4)) uut (.clk_i(clk_i),
        .rstn_i(rstn_i), .config_switch_i(sw), .rotary_i(rot),
        .sw_node_addr_i(sw_addr), .sw_init_mode_i(sw_init),
        .sw_lum_gate_i(sw_lum), .sw_sens_i(sw_sens),
        .sw_hold_code_i(sw_hold), .luminance_i(lumi), .motion_i(motion),
        .proto_ascii_o(proto), .sw_config_o(swc), .node_addr_o(addr),
        .init_mode_o(init), .lum_gate_o(lum), .sens_o(sens),
        .hold_code_o(hold), .relay_o(relay));
    function automatic logic [16:0] model(logic [9:0] s, logic [3:0] r);
        if (s[1])
            return {s[0], 1'b1, sw_init, sw_lum, sw_sens, sw_hold, sw_addr};
        return {s[0], 1'b0, s[3], s[4], s[5], s[6], s[7], s[8], s[9],
            8'(s[2] ? 176 + int'(r) : 160 + int'(r))};
    endfunction
    task automatic check(string n, logic [16:0] got, logic [16:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s exp %h got %h", n, exp, got);
        end
    endtask
    task automatic pulse(int cyc, logic exp);
        @(posedge clk_i) motion <= 1'b1;
        @(posedge clk_i) motion <= 1'b0;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i) check("relay_on", 17'(relay), 17'(exp));
        if (exp) begin
            repeat (cyc - 6) @(posedge clk_i);
            @(negedge clk_i) check("relay_held", 17'(relay), 17'h1);
            repeat (10) @(posedge clk_i);
            @(negedge clk_i) check("relay_off", 17'(relay), 17'h0);
        end
    endtask
    task automatic tally_and_finish();
        if (failures == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'h8856c496));
        repeat (9) @(posedge clk_i);
        @(negedge clk_i) check("reset", {proto, swc, init, lum, sens, hold,
            addr}, 17'h000a0);
        @(posedge clk_i) rstn_i <= 1'b1;
        repeat (30) begin
            @(posedge clk_i);
            bank.set_pos(10'($urandom), 4'($urandom));
            {sw_init, sw_lum, sw_sens, sw_hold} <= 7'($urandom);
            sw_addr <= 8'($urandom_range(255, 1));
            repeat (5) @(posedge clk_i);
            @(negedge clk_i) check("cfg", {proto, swc, init, lum, sens, hold,
                addr}, model(sw, rot));
        end
        for (int c = 0; c < 6; c++) begin
            @(posedge clk_i) bank.set_pos({1'(c), 1'(c >> 1), 1'(c >> 2),
                7'h00}, 4'h0);
            repeat (4) @(posedge clk_i);
            pulse(secs[c] * 4, 1'b1);
        end
        @(posedge clk_i) bank.set_pos(10'h010, 4'h0);
        lumi <= 8'hc9;
        repeat (4) @(posedge clk_i);
        pulse(0, 1'b0);
        @(posedge clk_i) lumi <= 8'hc8;
        pulse(24, 1'b1);
        tally_and_finish();
    end
endmodule // tb_dip_switch_config_decoder
`default_nettype wire
